//--- include/bcs_pkg.sv
package bcs_pkg;

	// ****************************************
	// strap decode
	// ****************************************
	localparam int          STRAP_W         = 12;
	localparam int          STEP_MV         = 100;
	localparam int          HALF_STEP_MV    = 50;
	localparam int          LEVEL_W         = 6;

	// ****************************************
	// capacity bounds
	// ****************************************
	localparam int          MAX_HOST        = 6;
	localparam int          MAX_NVME        = 12;
	localparam int          MAX_DRIVE       = 16;
	localparam int          DRIVES_PER_HOST = 2;

	// ****************************************
	// identifiers
	// ****************************************
	localparam logic [7:0]  ID_NONE         = 8'h00;
	localparam logic [7:0]  ID_SGPIO4       = 8'h01;
	localparam logic [7:0]  ID_SGPIO8       = 8'h02;
	localparam logic [7:0]  ID_SGPIO12      = 8'h03;
	localparam logic [7:0]  ID_SGPIO16      = 8'h04;
	localparam logic [7:0]  ID_UBM_U2_4     = 8'h05;
	localparam logic [7:0]  ID_UBM_U2_8     = 8'h06;
	localparam logic [7:0]  ID_UBM_U2_8F    = 8'h07;
	localparam logic [7:0]  ID_UBM_U3_8M    = 8'h08;
	localparam logic [7:0]  ID_UBM_U3_8F    = 8'h09;
	localparam logic [7:0]  ID_PCIE_U2_12   = 8'h0A;
	localparam logic [7:0]  ID_PCIE_U3_12   = 8'h0B;
	localparam logic [7:0]  ID_MIX_U2_8     = 8'h0D;

	typedef struct packed {
		logic [7:0] id;
		logic       sgpio;
		logic       ubm;
		logic       u3;
		logic [2:0] host_total;
		logic [2:0] host_sas;
		logic [2:0] host_pcie;
		logic [4:0] drv_total;
		logic [4:0] drv_sas;
		logic [4:0] drv_pcie;
	} bcs_cfg_s;

	localparam bcs_cfg_s    CFG_RESET       = '0;

	typedef enum logic [0:0] {
		BCS_WAIT,
		BCS_DONE
	} bcs_state_e;

endpackage

//--- core/bcs_top.sv
`timescale 1ns/100ps
// Operation
// - sample strap once, never change afterwards
// - 0.1-0.4 V give sideband ids 01-04
// - 0.5 V id 05, 0.6 V id 06
// - 0.7 V id 07, full U.2 UBM
// - 0.8/0.9 V ids 08/09, U.3 UBM
// - 1.0 V id 0A, 1.1 V id 0B
// - 1.3 V id 0D, UBM plus sideband
// - unlisted strap level is unsupported
// - host reset fans to two drives, no latency
// - one reset monitor per drive, tracked independently
// - insertion from detect, presence, U.3 second detect
// - report insertion, removal, failure to host
// - bound hosts six, NVMe twelve, drives sixteen
module bcs_top #(
	parameter int NHOST  = bcs_pkg::MAX_HOST,
	parameter int NDRIVE = bcs_pkg::MAX_DRIVE
) (
	input  wire logic                         clk,                        // core clock
	input  wire logic                         resetn,                     // async reset, active low
	input  wire logic [bcs_pkg::STRAP_W-1:0]  strap_mv,                   // digitized strap, millivolts
	input  wire logic                         strap_valid,                // strap sample ready
	input  wire logic [NHOST-1:0]             host_perst_n,               // host reset per host_conn
	input  wire logic [NDRIVE-1:0]            drive_perst_mon_n,          // reset monitor per drive_conn
	input  wire logic [NDRIVE-1:0]            drive_present_n,            // slot presence, low = present
	input  wire logic [NDRIVE-1:0]            drive_iface_detect_n,       // interface detect, low = drive
	input  wire logic [NDRIVE-1:0]            drive_iface_detect_second_n,// second detect, U.3 only
	input  wire logic [NDRIVE-1:0]            drive_fault,                // drive failure level
	output logic      [NDRIVE-1:0]            drive_perst_n,              // reset to drives
	output logic      [NDRIVE-1:0]            drive_perst_level,          // tracked reset monitor level
	output logic                              cfg_valid,                  // configuration latched
	output logic                              cfg_unsupported,            // strap not a valid level
	output logic      [7:0]                   cfg_id,                     // configuration identifier
	output logic                              cfg_sgpio,                  // sideband interface active
	output logic                              cfg_ubm,                    // ubm interface active
	output logic                              cfg_u3,                     // U.3 drive slots
	output logic      [2:0]                   host_conn_total,            // host_conn count
	output logic      [2:0]                   host_conn_sas,              // SAS host_conn count
	output logic      [2:0]                   host_conn_pcie,             // PCIe host_conn count
	output logic      [4:0]                   drive_conn_total,           // drive_conn count
	output logic      [4:0]                   drive_conn_sas,             // SAS/SATA drive_conn count
	output logic      [4:0]                   drive_conn_pcie,            // PCIe drive_conn count
	output logic      [NDRIVE-1:0]            slot_inserted,              // registered slot occupancy
	output logic      [NDRIVE-1:0]            evt_insert,                 // insertion pulse per slot
	output logic      [NDRIVE-1:0]            evt_remove,                 // removal pulse per slot
	output logic      [NDRIVE-1:0]            evt_fail,                   // failure pulse per slot
	output logic                              evt_to_ubm,                 // report pulse on ubm path
	output logic                              evt_to_sgpio                // report pulse on sideband path
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [4:0] sat5(input logic [4:0] v, input int lim);
		if (int'(v) > lim)
			sat5 = 5'(lim);
		else
			sat5 = v;
	endfunction

	function automatic logic [2:0] sat3(input logic [2:0] v, input int lim);
		if (int'(v) > lim)
			sat3 = 3'(lim);
		else
			sat3 = v;
	endfunction

	function automatic bcs_pkg::bcs_cfg_s mk(input logic [7:0] id, input logic sg, input logic ub,
		input logic u3, input logic [2:0] ht, input logic [2:0] hs, input logic [2:0] hp,
		input logic [4:0] dt, input logic [4:0] ds, input logic [4:0] dp);
		mk = '{id, sg, ub, u3, ht, hs, hp, dt, ds, dp};
	endfunction

	// ****************************************
	// strap decode
	// ****************************************
	logic [bcs_pkg::STRAP_W:0] rounded;
	logic [bcs_pkg::LEVEL_W-1:0] level;
	logic                      on_level;
	bcs_pkg::bcs_cfg_s         next_cfg;

	// round to the nearest step, then check the distance
	// exactly half a step off counts as unsupported
	always_comb begin
		rounded  = {1'b0, strap_mv} + (bcs_pkg::STRAP_W+1)'(bcs_pkg::HALF_STEP_MV);
		level    = bcs_pkg::LEVEL_W'(rounded / (bcs_pkg::STRAP_W+1)'(bcs_pkg::STEP_MV));
		on_level = (rounded % (bcs_pkg::STRAP_W+1)'(bcs_pkg::STEP_MV)) != '0;
		next_cfg = bcs_pkg::CFG_RESET;
		if (on_level) begin
			unique case (level)
				6'd1: begin
					next_cfg = mk(
						bcs_pkg::ID_SGPIO4,
						1'b1, 1'b0, 1'b0,
						3'd1, 3'd1, 3'd0,
						5'd4, 5'd4, 5'd0);
				end
				6'd2: begin
					next_cfg = mk(
						bcs_pkg::ID_SGPIO8,
						1'b1, 1'b0, 1'b0,
						3'd1, 3'd1, 3'd0,
						5'd8, 5'd8, 5'd0);
				end
				6'd3: begin
					next_cfg = mk(
						bcs_pkg::ID_SGPIO12,
						1'b1, 1'b0, 1'b0,
						3'd2, 3'd2, 3'd0,
						5'd12, 5'd12, 5'd0);
				end
				6'd4: begin
					next_cfg = mk(
						bcs_pkg::ID_SGPIO16,
						1'b1, 1'b0, 1'b0,
						3'd2, 3'd2, 3'd0,
						5'd16, 5'd16, 5'd0);
				end
				6'd5: begin
					next_cfg = mk(
						bcs_pkg::ID_UBM_U2_4,
						1'b0, 1'b1, 1'b0,
						3'd3, 3'd1, 3'd2,
						5'd4, 5'd4, 5'd4);
				end
				6'd6: begin
					next_cfg = mk(
						bcs_pkg::ID_UBM_U2_8,
						1'b0, 1'b1, 1'b0,
						3'd5, 3'd1, 3'd4,
						5'd8, 5'd8, 5'd8);
				end
				6'd7: begin
					next_cfg = mk(
						bcs_pkg::ID_UBM_U2_8F,
						1'b0, 1'b1, 1'b0,
						3'd5, 3'd1, 3'd4,
						5'd8, 5'd8, 5'd8);
				end
				6'd8: begin
					next_cfg = mk(
						bcs_pkg::ID_UBM_U3_8M,
						1'b0, 1'b1, 1'b1,
						3'd4, 3'd4, 3'd4,
						5'd8, 5'd8, 5'd8);
				end
				6'd9: begin
					next_cfg = mk(
						bcs_pkg::ID_UBM_U3_8F,
						1'b0, 1'b1, 1'b1,
						3'd4, 3'd4, 3'd4,
						5'd8, 5'd8, 5'd8);
				end
				6'd10: begin
					next_cfg = mk(
						bcs_pkg::ID_PCIE_U2_12,
						1'b0, 1'b1, 1'b0,
						3'd6, 3'd0, 3'd6,
						5'd12, 5'd0, 5'd12);
				end
				6'd11: begin
					next_cfg = mk(
						bcs_pkg::ID_PCIE_U3_12,
						1'b0, 1'b1, 1'b1,
						3'd6, 3'd0, 3'd6,
						5'd12, 5'd0, 5'd12);
				end
				6'd13: begin
					next_cfg = mk(
						bcs_pkg::ID_MIX_U2_8,
						1'b1, 1'b1, 1'b0,
						3'd5, 3'd1, 3'd4,
						5'd8, 5'd8, 5'd8);
				end
				default: begin
					next_cfg = bcs_pkg::CFG_RESET;
				end
			endcase
		end
	end

	// ****************************************
	// one-shot latch
	// ****************************************
	bcs_pkg::bcs_state_e state;

	// later strobes are ignored until the next reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state            <= bcs_pkg::BCS_WAIT;
			cfg_valid        <= 1'b0;
			cfg_unsupported  <= 1'b0;
			cfg_id           <= bcs_pkg::ID_NONE;
			cfg_sgpio        <= 1'b0;
			cfg_ubm          <= 1'b0;
			cfg_u3           <= 1'b0;
			host_conn_total  <= '0;
			host_conn_sas    <= '0;
			host_conn_pcie   <= '0;
			drive_conn_total <= '0;
			drive_conn_sas   <= '0;
			drive_conn_pcie  <= '0;
		end else begin
			unique case (state)
				bcs_pkg::BCS_WAIT: begin
					if (strap_valid) begin
						state            <= bcs_pkg::BCS_DONE;
						cfg_valid        <= next_cfg.id != bcs_pkg::ID_NONE;
						cfg_unsupported  <= next_cfg.id == bcs_pkg::ID_NONE;
						cfg_id           <= next_cfg.id;
						cfg_sgpio        <= next_cfg.sgpio;
						cfg_ubm          <= next_cfg.ubm;
						cfg_u3           <= next_cfg.u3;
						host_conn_total  <= sat3(next_cfg.host_total, bcs_pkg::MAX_HOST);
						host_conn_sas    <= sat3(next_cfg.host_sas, bcs_pkg::MAX_HOST);
						host_conn_pcie   <= sat3(next_cfg.host_pcie, bcs_pkg::MAX_HOST);
						drive_conn_total <= sat5(next_cfg.drv_total, bcs_pkg::MAX_DRIVE);
						drive_conn_sas   <= sat5(next_cfg.drv_sas, bcs_pkg::MAX_DRIVE);
						drive_conn_pcie  <= sat5(next_cfg.drv_pcie, bcs_pkg::MAX_NVME);
					end
				end
				bcs_pkg::BCS_DONE: begin
					state <= bcs_pkg::BCS_DONE;
				end
			endcase
		end
	end

	// ****************************************
	// drive reset path and monitors
	// ****************************************
	// combinational on purpose: the host owns reset timing
	always_comb begin
		for (int d = 0; d < NDRIVE; d++) begin
			if (d / bcs_pkg::DRIVES_PER_HOST < NHOST) begin
				drive_perst_n[d] = host_perst_n[d / bcs_pkg::DRIVES_PER_HOST];
			end else begin
				drive_perst_n[d] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_perst_level <= '0;
		end else begin
			drive_perst_level <= drive_perst_mon_n;
		end
	end

	// ****************************************
	// slot presence and events
	// ****************************************
	logic [NDRIVE-1:0] next_present;
	logic [NDRIVE-1:0] fault_prev;
	logic              live;

	// slots are watched only once a supported config is latched
	// failure edge is seen only on counted, inserted slots
	assign live = cfg_valid;

	always_comb begin
		for (int d = 0; d < NDRIVE; d++) begin
			next_present[d] = (d < int'(drive_conn_total)) && live &&
				(!drive_present_n[d] || !drive_iface_detect_n[d] ||
				(cfg_u3 && !drive_iface_detect_second_n[d]));
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_inserted <= '0;
			fault_prev    <= '0;
			evt_insert    <= '0;
			evt_remove    <= '0;
			evt_fail      <= '0;
		end else begin
			slot_inserted <= next_present;
			fault_prev    <= drive_fault & slot_inserted;
			evt_insert    <= next_present & ~slot_inserted;
			evt_remove    <= ~next_present & slot_inserted;
			evt_fail      <= drive_fault & slot_inserted & ~fault_prev;
		end
	end

	logic any_evt;

	assign any_evt = |{next_present ^ slot_inserted, drive_fault & slot_inserted & ~fault_prev};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_to_ubm   <= 1'b0;
			evt_to_sgpio <= 1'b0;
		end else begin
			evt_to_ubm   <= any_evt && cfg_ubm;
			evt_to_sgpio <= any_evt && cfg_sgpio;
		end
	end

endmodule

//--- dv/bcs_adc_model.sv
`timescale 1ns/100ps
module bcs_adc_model (
	input  wire logic        clk,          // core clock
	input  wire logic        resetn,       // active low reset
	input  wire logic [11:0] level_mv,     // divider voltage
	output logic      [11:0] strap_mv,     // digitized sample
	output logic             strap_valid,  // sample ready
	output logic      [5:0]  host_perst_n  // host reset per host_conn
);
	logic [11:0] mv     = 12'h000;
	logic        vld    = 1'b0;
	logic [5:0]  host   = 6'h3F;
	logic [1:0]  settle = 2'h0;
	assign {strap_mv, strap_valid, host_perst_n} = {mv, vld, host};
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle <= 2'h0;
			vld <= 1'b0;
		end else begin
			settle <= #2 settle + {1'b0, settle != 2'h3};
			vld <= #2 (settle == 2'h3);
			// sample keeps toggling after the converter settles
			mv <= #2 vld ? ~mv : level_mv;
		end
	end
	always @(posedge clk) host <= #2 {host[4:0], ~host[5]};
endmodule

//--- dv/bcs_top_asserts.sv
`timescale 1ns/100ps
module bcs_top_asserts #(
	parameter int NHOST  = 6,
	parameter int NDRIVE = 16
) (
	input wire logic              clk,               // clock
	input wire logic              resetn,            // reset
	input wire logic              strap_valid,       // strobe
	input wire logic [NHOST-1:0]  host_perst_n,      // host reset
	input wire logic [NDRIVE-1:0] drive_perst_mon_n, // monitor
	input wire logic [NDRIVE-1:0] drive_perst_n,     // drive reset
	input wire logic [NDRIVE-1:0] drive_perst_level, // tracked
	input wire logic              cfg_valid,         // latched
	input wire logic              cfg_unsupported,   // bad strap
	input wire logic [7:0]        cfg_id,            // id
	input wire logic              cfg_ubm,           // ubm
	input wire logic [4:0]        drive_conn_total,  // drives
	input wire logic [NDRIVE-1:0] slot_inserted,     // occupancy
	input wire logic [NDRIVE-1:0] evt_insert,        // insert
	input wire logic [NDRIVE-1:0] evt_fail,          // fail
	input wire logic              evt_to_ubm         // report
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [NDRIVE-1:0] fan;
	always_comb for (int d = 0; d < NDRIVE; d++) fan[d] = (d < 2 * NHOST) ? host_perst_n[d/2] : 1'b1;
	sequence s_take; strap_valid && !cfg_valid && !cfg_unsupported; endsequence
	sequence s_done; cfg_valid ^ cfg_unsupported; endsequence
	a_perst_fanout: assert property (drive_perst_n == fan)
		else $error("drive reset not a host copy");
	a_cfg_answer: assert property (s_take |=> s_done)
		else $error("strap not answered in one cycle");
	a_cfg_hold: assert property (cfg_valid |=> cfg_valid && $stable(cfg_id))
		else $error("configuration changed");
	a_unsup_id: assert property (cfg_unsupported |-> cfg_id == 8'h00 && !cfg_valid)
		else $error("unsupported strap gave an id");
	a_mon_track: assert property (resetn && $past(resetn) |=> drive_perst_level == $past(drive_perst_mon_n))
		else $error("monitor level not tracked");
	a_cap_bound: assert property (cfg_valid |-> drive_conn_total <= 5'h10 && cfg_id <= 8'h0D && cfg_id != 8'h0C)
		else $error("configuration out of bounds");
	a_slot_range: assert property ((slot_inserted >> drive_conn_total) == '0)
		else $error("slot above count occupied");
	a_insert_edge: assert property (##1 evt_insert == (slot_inserted & ~$past(slot_inserted)))
		else $error("insert event mismatch");
	a_fail_report: assert property (|evt_fail && cfg_ubm |-> evt_to_ubm)
		else $error("failure not reported");
	a_ubm_quiet: assert property (!cfg_ubm |-> !evt_to_ubm)
		else $error("report on inactive path");
endmodule
bind bcs_top bcs_top_asserts #(.NHOST(NHOST), .NDRIVE(NDRIVE)) u_asserts (.clk, .resetn, .strap_valid,
	.host_perst_n, .drive_perst_mon_n, .drive_perst_n, .drive_perst_level, .cfg_valid, .cfg_unsupported,
	.cfg_id, .cfg_ubm, .drive_conn_total, .slot_inserted, .evt_insert, .evt_fail, .evt_to_ubm);

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk = 0, resetn = 0, strap_valid, cfg_valid, cfg_unsupported, cfg_sgpio, cfg_ubm, cfg_u3;
	logic        evt_to_ubm, evt_to_sgpio;
	logic [11:0] lvl = 0, strap_mv;
	logic [5:0]  host_perst_n;
	logic [15:0] mon = 0, pres_n = '1, det_n = '1, det2_n = '1, fault = 0;
	logic [15:0] drive_perst_n, drive_perst_level, slot_inserted, evt_insert, evt_remove, evt_fail;
	logic [7:0]  cfg_id;
	logic [2:0]  ht, hs, hp;
	logic [4:0]  dt, ds, dp;
	int          num_errors = 0, checked = 0, cycles = 0;
	initial forever #25 clk = ~clk;
	bcs_adc_model adc (.clk, .resetn, .level_mv(lvl), .strap_mv, .strap_valid, .host_perst_n);
	bcs_top uut (.clk, .resetn, .strap_mv, .strap_valid, .host_perst_n, .drive_perst_mon_n(mon),
		.drive_present_n(pres_n), .drive_iface_detect_n(det_n), .drive_iface_detect_second_n(det2_n),
		.drive_fault(fault), .drive_perst_n, .drive_perst_level, .cfg_valid, .cfg_unsupported, .cfg_id, .cfg_sgpio,
		.cfg_ubm, .cfg_u3, .host_conn_total(ht), .host_conn_sas(hs), .host_conn_pcie(hp), .drive_conn_total(dt),
		.drive_conn_sas(ds), .drive_conn_pcie(dp), .slot_inserted, .evt_insert, .evt_remove, .evt_fail,
		.evt_to_ubm, .evt_to_sgpio);
	task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			conclude;
		end
	end
	task automatic step;
		logic [15:0] f;
		@(posedge clk);
		#2;
		for (int d = 0; d < 16; d++) f[d] = (d < 12) ? host_perst_n[d/2] : 1'b1;
		cmp("drive_perst_n", f, drive_perst_n);
		if (cfg_valid) cmp("drive_perst_level", mon, drive_perst_level);
		mon = 16'($urandom);
	endtask
	function automatic bcs_pkg::bcs_cfg_s exp_cfg(int mv);
		int n = (mv + 50) / 100;
		exp_cfg = '0;
		if (mv - 100 * n >= 50 || 100 * n - mv >= 50 || n == 0 || n == 12 || n > 13) return exp_cfg;
		case (n)
			1, 2, 3, 4: exp_cfg = {8'(n), 3'h4, (n > 2) ? 6'h12 : 6'h09, 3'h0, {2{5'(4 * n)}}, 5'h00};
			5: exp_cfg = {8'h05, 3'h2, 3'h3, 3'h1, 3'h2, {3{5'h04}}};
			6, 7: exp_cfg = {8'(n), 3'h2, 3'h5, 3'h1, 3'h4, {3{5'h08}}};
			8, 9: exp_cfg = {8'(n), 3'h3, {3{3'h4}}, {3{5'h08}}};
			10, 11: exp_cfg = {8'(n), 2'h1, 1'(n == 11), 3'h6, 3'h0, 3'h6, 5'h0C, 5'h00, 5'h0C};
			default: exp_cfg = {8'h0D, 3'h6, 3'h5, 3'h1, 3'h4, {3{5'h08}}};
		endcase
	endfunction
	task automatic run(int mv);
		bcs_pkg::bcs_cfg_s e;
		int s;
		e = exp_cfg(mv);
		resetn = 0;
		lvl = 12'(mv);
		{pres_n, det_n, det2_n, fault} = {{48{1'b1}}, 16'h0000};
		repeat (12) step;
		resetn = 1;
		for (int i = 0; i < 20 && !(cfg_valid || cfg_unsupported); i++) step;
		repeat (3) step;
		cmp("cfg", e, {cfg_id, cfg_sgpio, cfg_ubm, cfg_u3, ht, hs, hp, dt, ds, dp});
		cmp("cfg_valid", e.id != 0, cfg_valid);
		cmp("cfg_unsupported", e.id == 0, cfg_unsupported);
		if (e.id == 0) return;
		s = e.drv_total - 1;
		if (e.u3) det2_n[s] = 0;
		else if (mv % 2) pres_n[s] = 0;
		else det_n[s] = 0;
		// second detect on slot 0 must be ignored off U.3, slot above count too
		det2_n[0] = e.u3;
		if (s < 15) pres_n[s + 1] = 0;
		step;
		cmp("slot_inserted", 16'h1 << s, slot_inserted);
		cmp("evt_insert", 16'h1 << s, evt_insert);
		cmp("evt_to", {e.ubm, e.sgpio}, {evt_to_ubm, evt_to_sgpio});
		fault[s] = 1;
		step;
		cmp("evt_insert", 0, evt_insert);
		cmp("evt_fail", 16'h1 << s, evt_fail);
		{pres_n, det_n, det2_n} = '1;
		step;
		cmp("evt_remove", 16'h1 << s, evt_remove);
		cmp("slot_inserted", 0, slot_inserted);
	endtask
	initial begin
		int mvs[$] = '{0, 149, 150, 651, 1149, 1200, 1251, 1349, 1450};
		void'($urandom(32'h48a9160b));
		for (int n = 1; n <= 13; n++) mvs.push_back(100 * n);
		repeat (4) mvs.push_back(100 * $urandom_range(13, 1) + $urandom_range(98) - 49);
		foreach (mvs[i]) run(mvs[i]);
		conclude;
	end
endmodule
